// ==== rtl/spicfg_map.vh ====
`ifndef SPICFG_MAP_VH
`define SPICFG_MAP_VH
// Register indices; byte address is four times the index
`define SPICFG_IDX_MOD 6'h00
`define SPICFG_IDX_CFG 6'h01
`define SPICFG_IDX_IE 6'h02
`define SPICFG_IDX_DIV 6'h03
`define SPICFG_IDX_BUF 6'h04
`define SPICFG_IDX_RUN 6'h05
`define SPICFG_IDX_FLAG 6'h06
`define SPICFG_IDX_FCNT 6'h07
`define SPICFG_IDX_TOTAL 6'h0c
`define SPICFG_IDX_FIFO 6'h10
`define SPICFG_IDX_FCNT1 6'h13
`define SPICFG_IDX_DNOW 6'h14
`define SPICFG_IDX_DBEG 6'h18
`define SPICFG_IDX_DEND 6'h1c
// Mode control fields
`define SPICFG_MOD_MISO_OE 7
`define SPICFG_MOD_MOSI_OE 6
`define SPICFG_MOD_SCK_OE 5
`define SPICFG_MOD_RX_DIR 4
`define SPICFG_MOD_CMD_SCK3 3
`define SPICFG_MOD_CLEAR 1
`define SPICFG_MOD_SLAVE 0
// Configuration fields
`define SPICFG_CFG_DLY 6
`define SPICFG_CFG_LSB 5
`define SPICFG_CFG_AUTO 4
`define SPICFG_CFG_WRAP 2
`define SPICFG_CFG_DMA 0
`define SPICFG_CFG_MASK 8'h75
`define SPICFG_IE_MASK 8'h9f
// Flag fields
`define SPICFG_FLG_FIRST 7
`define SPICFG_FLG_FREE 6
`define SPICFG_FLG_OVF 4
`define SPICFG_FLG_DMA 3
`define SPICFG_FLG_HALF 2
`define SPICFG_FLG_BYTE 1
`define SPICFG_FLG_CNT 0
`define SPICFG_FLG_MASK 8'h9f
// Reset values
`define SPICFG_RST_MOD 8'h02
`define SPICFG_RST_DIV 8'h10
`define SPICFG_RST_ZERO 8'h00
// Divisor floor and FIFO shape
`define SPICFG_DIV_MIN 8'h02
`define SPICFG_FIFO_FULL 4'h8
`define SPICFG_FIFO_HALF 4'h4
`endif

// ==== rtl/spicfg_top.v ====
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "spicfg_map.vh"
module spicfg_top (
   input wire i_clk,
   input wire i_reset,
   input wire [7:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   output wire o_irq,
   output reg o_sck,
   output wire o_sck_oe,
   output reg o_mosi,
   output wire o_mosi_oe,
   input wire i_miso,
   output reg o_miso,
   output wire o_miso_oe,
   input wire i_sck,
   input wire i_mosi,
   input wire i_cs_n,
   output reg [14:0] o_dma_addr,
   output reg o_dma_rd,
   output reg o_dma_wr,
   output reg [7:0] o_dma_wdata,
   input wire [7:0] i_dma_rdata
);
   reg [7:0] mod_r, cfg_r, ie_r, div_r, buf_r, flag_r;
   reg [11:0] total_r;
   reg [14:0] dnow_r, dbeg_r, dend_r;
   reg [2:0] miso_s, sck_s;
   reg [1:0] mosi_s, cs_s;
   reg cs_prev_r;
   reg busy_r, first_r, cs_load_r, cmd_act_r, dma_pend_r;
   reg [7:0] cnt_r, sh_r;
   reg [3:0] bits_r;
   reg [7:0] fifo_mem [0:7];
   reg [2:0] wp_r, rp_r;
   reg [3:0] fcnt_r;

   function hit;
      input [5:0] idx;
      begin
         hit = (i_addr == {idx, 2'b00});
      end
   endfunction

   function nbit;
      input [7:0] x;
      input lsb;
      begin
         nbit = lsb ? x[0] : x[7];
      end
   endfunction

   wire slave = mod_r[`SPICFG_MOD_SLAVE];
   wire rxdir = mod_r[`SPICFG_MOD_RX_DIR];
   wire clr = mod_r[`SPICFG_MOD_CLEAR];
   wire lsb = cfg_r[`SPICFG_CFG_LSB];
   wire empty = (fcnt_r == 4'h0);
   wire full = (fcnt_r == `SPICFG_FIFO_FULL);
   wire [7:0] head = fifo_mem[rp_r];
   wire tot_nz = (total_r != 12'h000);

   // Divisor floor protects the half period from collapsing to zero
   wire [7:0] div_eff = (div_r < `SPICFG_DIV_MIN) ? `SPICFG_DIV_MIN : div_r;
   wire [7:0] half = {1'b0, div_eff[7:1]};
   wire m_rise = !slave && busy_r && (cnt_r == half - 8'h01);
   wire m_fall = !slave && busy_r && (cnt_r == div_eff - 8'h01);
   wire cs_act = !cs_s[1];
   wire s_rise = slave && cs_act && sck_s[1] && !sck_s[2];
   wire s_fall = slave && cs_act && !sck_s[1] && sck_s[2];
   // Master samples at the clock fall so the input flops see a settled bit
   wire rise = m_fall || s_rise;
   wire fall = m_fall || s_fall;
   // Extra stage trades a cycle of latency for margin near Fsys/2
   wire din_m = cfg_r[`SPICFG_CFG_DLY] ? miso_s[2] : miso_s[1];
   wire din = slave ? mosi_s[1] : din_m;
   wire [7:0] sh_in = lsb ? {din, sh_r[7:1]} : {sh_r[6:0], din};
   wire byte_end = rise && (bits_r == 4'h7);
   wire cs_rise = slave && cs_act && !cs_prev_r;

   wire sw_buf_wr = i_wr && hit(`SPICFG_IDX_BUF);
   wire sw_buf_acc = (i_wr || i_rd) && (hit(`SPICFG_IDX_BUF) || hit(`SPICFG_IDX_FIFO));
   wire dma_en = cfg_r[`SPICFG_CFG_DMA];
   wire m_start_sw = !slave && !busy_r && sw_buf_wr && !clr;
   wire m_start_auto = !slave && !busy_r && !sw_buf_wr && tot_nz && !clr &&
                       (rxdir ? !full : !empty);
   wire [7:0] m_load = m_start_sw ? i_wdata[7:0] : (rxdir ? 8'hff : head);

   // Software FIFO port is shut while DMA owns it, so pushes never collide
   wire sw_fifo_wr = i_wr && hit(`SPICFG_IDX_FIFO) && !rxdir && !dma_en && !full;
   wire sw_fifo_rd = i_rd && hit(`SPICFG_IDX_FIFO) && rxdir && !dma_en && !empty;
   wire s_pop = slave && byte_end && !first_r && !rxdir && !empty;
   wire eng_push = byte_end && rxdir && !full;
   wire dma_run = dma_en && tot_nz && !clr && (dnow_r != dend_r);
   wire dma_issue = dma_run && !rxdir && !dma_pend_r && !full;
   wire dma_pop = dma_run && rxdir && !empty;
   wire dma_push = dma_pend_r && !full;
   wire push = sw_fifo_wr || eng_push || dma_push;
   wire pop = sw_fifo_rd || (m_start_auto && !rxdir) || s_pop || dma_pop;
   wire [7:0] push_d = eng_push ? sh_in : (dma_push ? i_dma_rdata : i_wdata[7:0]);
   wire [14:0] dnext = dnow_r + 15'h0001;
   wire dma_step = dma_issue || dma_pop;

   wire ovf = byte_end && (rxdir ? full : (slave && !first_r && empty));
   wire half_hit = rxdir ? (fcnt_r >= `SPICFG_FIFO_HALF) : (fcnt_r < `SPICFG_FIFO_HALF);
   wire first_evt = slave && byte_end && first_r;
   wire m_dec = !slave && byte_end && tot_nz;
   wire fifo_ready = tot_nz && (rxdir ? !full : !empty);

   reg [7:0] fset, fclr;
   always @* begin
      fset = 8'h00;
      fset[`SPICFG_FLG_FIRST] = first_evt && mod_r[`SPICFG_MOD_CMD_SCK3];
      fset[`SPICFG_FLG_OVF] = ovf;
      fset[`SPICFG_FLG_DMA] = dma_step && (dnext == dend_r);
      fset[`SPICFG_FLG_HALF] = half_hit;
      fset[`SPICFG_FLG_BYTE] = byte_end;
      fset[`SPICFG_FLG_CNT] = m_dec && (total_r == 12'h001);
      fclr = 8'h00;
      if (i_wr && hit(`SPICFG_IDX_FLAG))
         fclr = i_wdata[7:0] & `SPICFG_FLG_MASK;
      if (sw_buf_acc && cfg_r[`SPICFG_CFG_AUTO])
         fclr[`SPICFG_FLG_BYTE] = 1'b1;
   end

   // Each enable bit gates the flag in the same position
   assign o_irq = |(flag_r & ie_r & `SPICFG_IE_MASK);
   assign o_sck_oe = mod_r[`SPICFG_MOD_SCK_OE];
   assign o_mosi_oe = mod_r[`SPICFG_MOD_MOSI_OE];
   assign o_miso_oe = mod_r[`SPICFG_MOD_MISO_OE];

   always @(posedge i_clk) begin
      miso_s <= {miso_s[1:0], i_miso};
      sck_s <= {sck_s[1:0], i_sck};
      mosi_s <= {mosi_s[0], i_mosi};
      cs_s <= {cs_s[0], i_cs_n};
   end

   // Register file and flags
   always @(posedge i_clk) begin
      if (i_reset) begin
         mod_r <= `SPICFG_RST_MOD;
         cfg_r <= `SPICFG_RST_ZERO;
         ie_r <= `SPICFG_RST_ZERO;
         div_r <= `SPICFG_RST_DIV;
         flag_r <= `SPICFG_RST_ZERO;
         total_r <= 12'h000;
         dnow_r <= 15'h0000;
         dbeg_r <= 15'h0000;
         dend_r <= 15'h0000;
      end else begin
         if (i_wr) begin
            if (hit(`SPICFG_IDX_MOD))
               mod_r <= i_wdata[7:0];
            if (hit(`SPICFG_IDX_CFG))
               cfg_r <= i_wdata[7:0] & `SPICFG_CFG_MASK;
            if (hit(`SPICFG_IDX_IE))
               ie_r <= i_wdata[7:0] & `SPICFG_IE_MASK;
            if (hit(`SPICFG_IDX_DIV))
               div_r <= i_wdata[7:0];
            if (hit(`SPICFG_IDX_DBEG))
               dbeg_r <= i_wdata[14:0];
            if (hit(`SPICFG_IDX_DEND))
               dend_r <= i_wdata[14:0];
         end
         if (clr) begin
            flag_r <= `SPICFG_RST_ZERO;
            total_r <= 12'h000;
         end else begin
            flag_r <= (flag_r & ~fclr) | fset;
            if (i_wr && hit(`SPICFG_IDX_TOTAL))
               total_r <= i_wdata[11:0];
            else if (m_dec)
               total_r <= total_r - 12'h001;
         end
         if (i_wr && hit(`SPICFG_IDX_DNOW))
            dnow_r <= i_wdata[14:0];
         else if (dma_step)
            dnow_r <= (dnext == dend_r && cfg_r[`SPICFG_CFG_WRAP]) ? dbeg_r : dnext;
      end
   end

   // DMA master port
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_dma_addr <= 15'h0000;
         o_dma_rd <= 1'b0;
         o_dma_wr <= 1'b0;
         o_dma_wdata <= 8'h00;
         dma_pend_r <= 1'b0;
      end else begin
         o_dma_rd <= dma_issue;
         o_dma_wr <= dma_pop;
         dma_pend_r <= dma_issue;
         if (dma_step)
            o_dma_addr <= dnow_r;
         if (dma_pop)
            o_dma_wdata <= head;
      end
   end

   // FIFO
   always @(posedge i_clk) begin
      if (i_reset || clr) begin
         wp_r <= 3'h0;
         rp_r <= 3'h0;
         fcnt_r <= 4'h0;
      end else begin
         if (push)
            wp_r <= wp_r + 3'h1;
         if (pop)
            rp_r <= rp_r + 3'h1;
         if (push && !pop)
            fcnt_r <= fcnt_r + 4'h1;
         else if (pop && !push)
            fcnt_r <= fcnt_r - 4'h1;
      end
   end

   always @(posedge i_clk) begin
      if (push)
         fifo_mem[wp_r] <= push_d;
   end

   // Serial engine
   always @(posedge i_clk) begin
      if (i_reset) begin
         busy_r <= 1'b0;
         cnt_r <= 8'h00;
         bits_r <= 4'h0;
         sh_r <= 8'h00;
         buf_r <= 8'h00;
         first_r <= 1'b0;
         cs_load_r <= 1'b0;
         cmd_act_r <= 1'b0;
         cs_prev_r <= 1'b0;
         o_mosi <= 1'b0;
         o_miso <= 1'b0;
         o_sck <= 1'b0;
      end else begin
         cs_prev_r <= slave && cs_act;
         if (!busy_r)
            o_sck <= mod_r[`SPICFG_MOD_CMD_SCK3];
         if (sw_buf_wr && slave)
            buf_r <= i_wdata[7:0];
         if (m_start_sw || m_start_auto) begin
            busy_r <= 1'b1;
            cnt_r <= 8'h00;
            bits_r <= 4'h0;
            sh_r <= m_load;
            o_mosi <= nbit(m_load, lsb);
         end else if (busy_r) begin
            cnt_r <= m_fall ? 8'h00 : cnt_r + 8'h01;
            if (m_rise)
               o_sck <= 1'b1;
            if (m_fall) begin
               // Clock and data move on one edge, so data changes while clock is high only at a start with SPICFG_MOD_CMD_SCK3 idling it high
               o_sck <= 1'b0;
               o_mosi <= nbit(sh_in, lsb);
               if (bits_r == 4'h7)
                  busy_r <= 1'b0;
            end
         end
         if (cs_rise) begin
            sh_r <= buf_r;
            o_miso <= nbit(buf_r, lsb);
            bits_r <= 4'h0;
            first_r <= 1'b1;
            cs_load_r <= 1'b1;
         end else if (slave && !cs_act) begin
            bits_r <= 4'h0;
            first_r <= 1'b0;
            cs_load_r <= 1'b0;
            cmd_act_r <= 1'b0;
         end
         if (s_fall)
            o_miso <= nbit(sh_r, lsb);
         if (rise) begin
            sh_r <= sh_in;
            bits_r <= bits_r + 4'h1;
            cmd_act_r <= 1'b0;
         end
         if (byte_end) begin
            buf_r <= sh_in;
            if (slave) begin
               bits_r <= 4'h0;
               if (first_r) begin
                  sh_r <= div_r;
                  first_r <= 1'b0;
                  cs_load_r <= 1'b0;
                  cmd_act_r <= 1'b1;
               end else if (!rxdir && !empty)
                  sh_r <= head;
               else
                  sh_r <= 8'hff;
            end
         end
      end
   end

   // Read port; data valid only in the cycle after the strobe
   always @(posedge i_clk) begin
      if (i_reset || !i_rd)
         o_rdata <= 16'h0000;
      else begin
         o_rdata <= 16'h0000;
         if (hit(`SPICFG_IDX_MOD))
            o_rdata <= {8'h00, mod_r};
         if (hit(`SPICFG_IDX_CFG))
            o_rdata <= {8'h00, cfg_r};
         if (hit(`SPICFG_IDX_IE))
            o_rdata <= {8'h00, ie_r};
         if (hit(`SPICFG_IDX_DIV))
            o_rdata <= {8'h00, div_r};
         if (hit(`SPICFG_IDX_BUF))
            o_rdata <= {8'h00, buf_r};
         if (hit(`SPICFG_IDX_RUN))
            o_rdata <= {8'h00, slave && cs_act, cs_load_r, fifo_ready, cmd_act_r, 4'h0};
         if (hit(`SPICFG_IDX_FLAG))
            o_rdata <= {8'h00, flag_r[7], !(busy_r || (slave && cs_act)), 1'b0, flag_r[4:0]};
         if (hit(`SPICFG_IDX_FCNT) || hit(`SPICFG_IDX_FCNT1))
            o_rdata <= {12'h000, fcnt_r};
         if (hit(`SPICFG_IDX_TOTAL))
            o_rdata <= {4'h0, total_r};
         if (hit(`SPICFG_IDX_FIFO))
            o_rdata <= {8'h00, head};
         if (hit(`SPICFG_IDX_DNOW))
            o_rdata <= {1'b0, dnow_r};
         if (hit(`SPICFG_IDX_DBEG))
            o_rdata <= {1'b0, dbeg_r};
         if (hit(`SPICFG_IDX_DEND))
            o_rdata <= {1'b0, dend_r};
      end
   end
endmodule // spicfg_top

// ==== verif/spicfg_slave_model.sv ====
`timescale 1ns/100ps
module spicfg_slave_model (
   input wire i_clk,
   input wire i_sel,
   input wire i_sck,
   input wire i_mosi,
   input wire [7:0] i_reply,
   output wire o_miso,
   output logic [7:0] o_got
);
   logic [2:0] nbit = 3'h0;
   logic idl = 1'b0;
   // Mode 0 device: samples on SCK rise, shifts out MSB first on fall
   always @(negedge i_sck or negedge i_sel) begin
      if (!i_sel) nbit <= 3'h0;
      else nbit <= nbit + 3'h1;
   end
   always @(posedge i_sck) begin
      if (i_sel) o_got <= {o_got[6:0], i_mosi};
   end
   // Deselected line toggles so a stale bit can never pass as data
   always @(posedge i_clk) begin
      idl <= ~idl;
   end
   assign o_miso = i_sel ? i_reply[3'h7 - nbit] : idl;
endmodule // spicfg_slave_model

// ==== verif/spicfg_asserts.sv ====
`timescale 1ns/100ps
module spicfg_asserts (
   input wire i_clk,
   input wire i_reset,
   input wire [7:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [15:0] o_rdata,
   input wire o_irq,
   input wire o_sck,
   input wire o_mosi
);
   localparam [7:0] A_CFG = 8'h04, A_IE = 8'h08, A_DIV = 8'h0c, A_RUN = 8'h14;
   logic [7:0] div_r, ie_r, hi_cnt, lo_cnt;
   wire [7:0] dv = (div_r < 8'h02) ? 8'h02 : div_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   always @(posedge i_clk) begin
      if (i_reset) begin
         div_r <= 8'h10;
         ie_r <= 8'h00;
         hi_cnt <= 8'h00;
         lo_cnt <= 8'h00;
      end else begin
         if (i_wr && i_addr == A_DIV) div_r <= i_wdata[7:0];
         if (i_wr && i_addr == A_IE) ie_r <= i_wdata[7:0];
         hi_cnt <= o_sck ? hi_cnt + 8'h01 : 8'h00;
         // Saturate so a long idle never wraps into a short count
         lo_cnt <= o_sck ? 8'h00 : ((lo_cnt == 8'hff) ? lo_cnt : lo_cnt + 8'h01);
      end
   end
   property p_cfg_rsv;
      $past(i_rd) && $past(i_addr) == A_CFG |-> (o_rdata & 16'hff8a) == 16'h0000;
   endproperty
   a_cfg_rsv: assert property (p_cfg_rsv) else $error("config reserved bits set");
   property p_ie_rsv;
      $past(i_rd) && $past(i_addr) == A_IE |-> (o_rdata & 16'hff60) == 16'h0000;
   endproperty
   a_ie_rsv: assert property (p_ie_rsv) else $error("enable reserved bits set");
   property p_run_rsv;
      $past(i_rd) && $past(i_addr) == A_RUN |-> (o_rdata & 16'hff0f) == 16'h0000;
   endproperty
   a_run_rsv: assert property (p_run_rsv) else $error("status reserved bits set");
   property p_div_rd;
      $past(i_rd) && $past(i_addr) == A_DIV |-> o_rdata == {8'h00, div_r};
   endproperty
   a_div_rd: assert property (p_div_rd) else $error("divisor readback wrong");
   property p_irq_off;
      (ie_r & 8'h9f) == 8'h00 |-> !o_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq with no enable");
   property p_sck_hi;
      $fell(o_sck) |-> hi_cnt == dv - (dv >> 1);
   endproperty
   a_sck_hi: assert property (p_sck_hi) else $error("serial clock high time wrong");
   property p_sck_lo;
      $rose(o_sck) |-> lo_cnt >= (dv >> 1);
   endproperty
   a_sck_lo: assert property (p_sck_lo) else $error("serial clock low too short");
   property p_mosi;
      $changed(o_mosi) |-> !o_sck;
   endproperty
   a_mosi: assert property (p_mosi) else $error("data moved at sample edge");
   c_irq: cover property ($rose(o_irq));
   c_sck: cover property ($fell(o_sck));
   c_run: cover property ($past(i_rd) && $past(i_addr) == A_RUN);
endmodule // spicfg_asserts

// ==== verif/spi_config_irq_status_bench.sv ====
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module spi_config_irq_status_bench;
   localparam [7:0] MOD = 8'h00, CFG = 8'h04, IE = 8'h08, DIV = 8'h0c, BUF = 8'h10;
   localparam [7:0] RUN = 8'h14, FLG = 8'h18, TOT = 8'h30, FIFO = 8'h40;
   logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, sel = 0;
   logic [7:0] i_addr = 0, reply = 0;
   logic [15:0] i_wdata = 0, rdv;
   wire [15:0] o_rdata;
   wire o_irq, o_sck, o_mosi, miso;
   wire [7:0] got;
   int fail_count = 0, n_tests = 0;
   spicfg_top u_spicfg_top (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_sck(o_sck), .o_sck_oe(), .o_mosi(o_mosi), .o_mosi_oe(), .i_miso(miso), .o_miso(),
      .o_miso_oe(), .i_sck(1'b0), .i_mosi(1'b0), .i_cs_n(1'b1), .o_dma_addr(), .o_dma_rd(),
      .o_dma_wr(), .o_dma_wdata(), .i_dma_rdata(8'h00));
   spicfg_slave_model u_spicfg_slave_model (.i_clk(i_clk), .i_sel(sel), .i_sck(o_sck),
      .i_mosi(o_mosi), .i_reply(reply), .o_miso(miso), .o_got(got));
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   task automatic wr(input [7:0] a, input [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, output [15:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic rc(input [7:0] a, input [15:0] e);
      logic [15:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask
   task automatic wait_flag(input [7:0] m);
      int k;
      rd(FLG, rdv);
      for (k = 0; k < 200 && (rdv[7:0] & m) !== m; k++) rd(FLG, rdv);
      `CHK(rdv[7:0] & m, m)
   endtask
   // One master byte: shifted pattern seen by the device and byte returned
   task automatic t_byte(input [7:0] cf, dv, tx, rp, eg, eb);
      wr(MOD, 16'h0060);
      wr(DIV, {8'h00, dv});
      wr(CFG, {8'h00, cf});
      wr(IE, 16'h0002);
      reply <= rp;
      sel <= 1'b1;
      wr(BUF, {8'h00, tx});
      wait_flag(8'h42);
      `CHK(got, eg)
      `CHK(o_irq, 1'b1)
      rd(BUF, rdv);
      `CHK(rdv[7:0], eb)
      `CHK(o_irq, !cf[4])
      wr(FLG, 16'h0002);
      #1 `CHK(o_irq, 1'b0)
      sel = 1'b0;
   endtask
   task automatic t_stream;
      wr(CFG, 16'h0000);
      wr(IE, 16'h0001);
      wr(FIFO, 16'h0011);
      wr(FIFO, 16'h0066);
      rc(RUN, 16'h0000);
      sel <= 1'b1;
      wr(TOT, 16'h0002);
      wait_flag(8'h41);
      `CHK(got, 8'h66)
      `CHK(o_irq, 1'b1)
      rc(TOT, 16'h0000);
      sel = 1'b0;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #1000000;
      fail_count++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      rc(DIV, 16'h0010);
      rc(CFG, 16'h0000);
      rc(IE, 16'h0000);
      rc(RUN, 16'h0000);
      rc(8'h20, 16'h0000);
      wr(CFG, 16'hffff);
      rc(CFG, 16'h0075);
      wr(IE, 16'hffff);
      rc(IE, 16'h009f);
      `CHK(o_irq, 1'b0)
      t_byte(8'h00, 8'h04, 8'ha5, 8'h35, 8'ha5, 8'h35);
      t_byte(8'h70, 8'h06, 8'h1b, 8'h35, 8'hd8, 8'hac);
      t_stream;
      complete_run;
   end
endmodule // spi_config_irq_status_bench
bind spicfg_top spicfg_asserts u_spicfg_asserts (.i_clk(i_clk), .i_reset(i_reset),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_irq(o_irq), .o_sck(o_sck), .o_mosi(o_mosi));
